// >>> rtl/bsx_exec.sv
`timescale 1ns/1ps
`include "bsx_defines.svh"
// Operation
// RULE1: Skip next instruction when tested bit is one
// RULE2: Discard prefetched word on skip
// RULE3: Run no-op instead; one or two cycles
// RULE4: Call pushes PC plus one onto stack
// RULE5: Literal eleven bits load PC bits 10:0
// RULE6: Latch bits 4:3 give PC 12:11; two cycles
// RULE7: Decode fixed encodings; no status flags touched
module bsx_exec
  import bsx_pkg::*;
#(
  parameter int PC_W = 13
)(
  // Clock, reset, enable
  input  wire logic      ref_clk,
  input  wire logic      arst_n,
  input  wire logic      clkEn,
  // Fetch path: word fetched in the previous cycle
  input  wire bsx_word_t fetchWord,
  // Register file read port
  output logic [6:0]     fileRdAddr,
  input  wire logic [7:0] fileRdData,
  // High-address latch
  input  wire logic [7:0] programCounterHighLatch,
  // Program counter and stack
  output bsx_pc_t        progCounter,
  output logic           stackPush,
  output bsx_pc_t        stackTopEntry,
  // Execute-stage view
  output bsx_word_t      execWord,
  output logic           execValid,
  output logic           skipTaken
);
  // Page and literal split is fixed, so refuse any other width at elaboration
  if (PC_W != 13) begin : gPcWidthChk
    $error("bsx_exec supports only a 13-bit program counter");
  end

  // Sequential fetch address; wraps at the top of program memory
  function automatic bsx_pc_t pcStep(input bsx_pc_t pc);
    pcStep = pc + 13'h0001;
  endfunction

  // Call target: latch page bits above the eleven-bit literal
  function automatic bsx_pc_t callTarget(input logic [7:0] latch, input logic [10:0] lit);
    callTarget = {latch[`BSX_LATCH_HI:`BSX_LATCH_LO], lit};
  endfunction

  logic        isBitTestSet;
  logic        isCall;
  logic [6:0]  fileAddr;
  logic [2:0]  bitSel;
  logic [10:0] callLit;

  bsx_decode uDecode (
    .instrWord    (fetchWord),
    .isBitTestSet (isBitTestSet),
    .isCall       (isCall),
    .fileAddr     (fileAddr),
    .bitSel       (bitSel),
    .callLit      (callLit)
  );

  bsx_state_e state_r, state_nxt;
  bsx_pc_t    pc_r, pc_nxt;
  bsx_pc_t    retAddr_r, retAddr_nxt;
  logic       push_r, push_nxt;
  logic       skip_r, skip_nxt;
  bsx_word_t  word_r, word_nxt;
  logic       valid_r, valid_nxt;
  logic       bitHit;

  assign fileRdAddr = fileAddr;
  assign bitHit     = fileRdData[bitSel]; // RULE1

  always_comb begin
    state_nxt = state_r;
    pc_nxt      = pcStep(pc_r);
    retAddr_nxt = retAddr_r;
    push_nxt  = 1'b0;
    skip_nxt  = 1'b0;
    word_nxt  = fetchWord;
    valid_nxt = 1'b1;
    unique case (state_r)
      BSX_EXEC: begin
        if (isBitTestSet && bitHit) begin
          state_nxt = BSX_FLUSH; // RULE1
          skip_nxt  = 1'b1;
        end else if (isCall) begin
          // PC already points past the call word, so it is the return address
          retAddr_nxt = pc_r; // RULE4
          push_nxt    = 1'b1; // RULE4
          pc_nxt      = callTarget(programCounterHighLatch, callLit); // RULE5 RULE6
          state_nxt = BSX_CALL2; // RULE6
        end
      end
      BSX_FLUSH: begin
        // Prefetched word is dropped so it cannot write anything
        word_nxt  = `BSX_NOP_WORD; // RULE2 RULE3
        valid_nxt = 1'b0; // RULE2
        state_nxt = BSX_EXEC; // RULE3
      end
      BSX_CALL2: begin
        // Word fetched before the jump is stale; second cycle is a no-op
        word_nxt  = `BSX_NOP_WORD; // RULE6
        valid_nxt = 1'b0;
        state_nxt = BSX_EXEC;
      end
      default: begin
        state_nxt = BSX_EXEC;
        pc_nxt    = pc_r;
        valid_nxt = 1'b0;
        word_nxt  = `BSX_NOP_WORD;
      end
    endcase
  end

  // Enable gates every register so a stalled core keeps its place in the stream
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= BSX_EXEC;
      pc_r    <= `BSX_PC_RST;
      retAddr_r <= `BSX_PC_RST;
      push_r  <= 1'b0;
      skip_r  <= 1'b0;
      word_r  <= `BSX_NOP_WORD;
      valid_r <= 1'b0;
    end else if (clkEn) begin
      state_r <= state_nxt;
      pc_r    <= pc_nxt;
      retAddr_r <= retAddr_nxt;
      push_r  <= push_nxt;
      skip_r  <= skip_nxt;
      word_r  <= word_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign progCounter   = pc_r;
  assign stackTopEntry = retAddr_r;
  assign stackPush     = push_r;
  assign skipTaken     = skip_r;
  assign execWord      = word_r;
  assign execValid     = valid_r;

  // Skip path
  skip_flush_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE2
    clkEn && state_r == BSX_EXEC && isBitTestSet && bitHit ##1 clkEn |=> !execValid)
    else $error("skipped word was not discarded");

  skip_nop_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE3
    state_r == BSX_FLUSH && clkEn |=> execWord == 14'h0000 && state_r == BSX_EXEC)
    else $error("skip did not end in one no-op cycle");

  noskip_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE1
    clkEn && state_r == BSX_EXEC && isBitTestSet && !bitHit |=> !skipTaken && execValid)
    else $error("skip taken with clear bit");

  skip_enter_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE1
    clkEn && state_r == BSX_EXEC && isBitTestSet && bitHit
    |=> state_r == BSX_FLUSH && skipTaken)
    else $error("set bit did not start a skip");

  flush_nocall_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE2
    clkEn && state_r == BSX_FLUSH |=> !stackPush && progCounter == pcStep($past(pc_r)))
    else $error("discarded word changed program flow");

  skip_pulse_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE3
    clkEn && state_r == BSX_FLUSH |=> !skipTaken && state_r == BSX_EXEC)
    else $error("skip lasted more than one extra cycle");

  // Call path
  call_push_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE4
    clkEn && state_r == BSX_EXEC && isCall && !(isBitTestSet && bitHit)
    |=> stackPush && stackTopEntry == $past(pc_r))
    else $error("call pushed wrong return address");

  call_low_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE5
    clkEn && state_r == BSX_EXEC && isCall |=> progCounter[10:0] == $past(callLit))
    else $error("call literal not loaded");

  call_high_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE6
    clkEn && state_r == BSX_EXEC && isCall
    |=> progCounter[12:11] == $past(programCounterHighLatch[4:3]))
    else $error("call page bits wrong");

  call_two_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE6
    clkEn && state_r == BSX_EXEC && isCall ##1 clkEn |=> state_r == BSX_EXEC && !execValid)
    else $error("call not two cycles");

  call_gap_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE6
    clkEn && state_r == BSX_CALL2 |=> !stackPush && !execValid && execWord == 14'h0000)
    else $error("call second cycle was not a no-op");

  push_once_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE4
    stackPush |-> state_r == BSX_CALL2)
    else $error("push outside call");

  top_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE4
    !(clkEn && state_r == BSX_EXEC && isCall) |=> $stable(stackTopEntry))
    else $error("return address moved without a call");

  // Whole block
  seq_step_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE3
    clkEn && (state_r == BSX_FLUSH || state_r == BSX_CALL2 || (state_r == BSX_EXEC && !isCall))
    |=> progCounter == pcStep($past(pc_r)))
    else $error("program counter did not step by one");

  plain_exec_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE7
    clkEn && state_r == BSX_EXEC && !isCall && !(isBitTestSet && bitHit)
    |=> execValid && !skipTaken && !stackPush && execWord == $past(fetchWord))
    else $error("plain word not retired unchanged");

  // Clock enable low must hold every register, the push pulse included
  freeze_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !clkEn |=> $stable(state_r) && $stable(pc_r) && $stable(retAddr_r) && $stable(word_r)
    && $stable(push_r) && $stable(skip_r) && $stable(valid_r))
    else $error("state moved while clock enable was low");

  state_legal_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $onehot(state_r))
    else $error("sequencer left its one-hot codes");
endmodule

// >>> rtl/bsx_defines.svh
`ifndef BSX_DEFINES_SVH
`define BSX_DEFINES_SVH
`define BSX_OPC_BTSS     4'h7
`define BSX_OPC_CALL     3'h4
`define BSX_FADDR_LSB    0
`define BSX_FADDR_MSB    6
`define BSX_BIT_LSB      7
`define BSX_BIT_MSB      9
`define BSX_LIT_MSB      10
`define BSX_LATCH_LO     3
`define BSX_LATCH_HI     4
`define BSX_PC_RST       13'h0000
`define BSX_NOP_WORD     14'h0000
`endif

// >>> rtl/bsx_pkg.sv
package bsx_pkg;
  typedef logic [13:0] bsx_word_t;
  typedef logic [12:0] bsx_pc_t;
  typedef enum logic [2:0] {
    BSX_EXEC  = 3'h1,
    BSX_FLUSH = 3'h2,
    BSX_CALL2 = 3'h4
  } bsx_state_e;
endpackage

// >>> rtl/bsx_decode.sv
`timescale 1ns/1ps
`include "bsx_defines.svh"
module bsx_decode
  import bsx_pkg::*;
(
  // Instruction word
  input  wire bsx_word_t instrWord,
  // Decoded fields
  output logic           isBitTestSet,
  output logic           isCall,
  output logic [6:0]     fileAddr,
  output logic [2:0]     bitSel,
  output logic [10:0]    callLit
);
  always_comb begin
    isBitTestSet = (instrWord[13:10] == `BSX_OPC_BTSS); // RULE7
    isCall       = (instrWord[13:11] == `BSX_OPC_CALL); // RULE7
    fileAddr     = instrWord[`BSX_FADDR_MSB:`BSX_FADDR_LSB];
    bitSel       = instrWord[`BSX_BIT_MSB:`BSX_BIT_LSB];
    callLit      = instrWord[`BSX_LIT_MSB:0];
  end
endmodule

// >>> bench/bsx_pmem_model.sv
`timescale 1ns/1ps
module bsx_pmem_model
  import bsx_pkg::*;
(
  // Clock and reset
  input  wire logic      ref_clk,
  input  wire logic      arst_n,
  input  wire logic      clkEn,
  // Fetch path
  input  wire bsx_pc_t   progCounter,
  output bsx_word_t      fetchWord
);
  bsx_word_t mem [0:8191];
  // Unloaded words read as no-op so a stray fetch never goes unknown
  initial begin
    foreach (mem[i]) mem[i] = 14'h0000;
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) fetchWord <= 14'h0000;
    else if (clkEn) fetchWord <= mem[progCounter];
  end
endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import bsx_pkg::*;
  logic       ref_clk = 1'b0;
  logic       arst_n  = 1'b0;
  logic       clkEn   = 1'b1;
  logic [7:0] regVal  = 8'h00;
  logic [7:0] latch   = 8'h00;
  logic [7:0] fileRdData;
  logic [6:0] fileRdAddr;
  bsx_word_t  fetchWord, execWord;
  bsx_pc_t    progCounter, stackTopEntry;
  logic       stackPush, execValid, skipTaken;
  int         err_count = 0;
  int         checks = 0;
  always #5 ref_clk = ~ref_clk;
  // Only file 5 holds the tested value; others read zero
  assign fileRdData = (fileRdAddr == 7'h05) ? regVal : 8'h00;
  bsx_exec i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .clkEn(clkEn),
    .fetchWord(fetchWord), .fileRdAddr(fileRdAddr), .fileRdData(fileRdData),
    .programCounterHighLatch(latch), .progCounter(progCounter),
    .stackPush(stackPush), .stackTopEntry(stackTopEntry), .execWord(execWord),
    .execValid(execValid), .skipTaken(skipTaken));
  bsx_pmem_model i_mem (.ref_clk(ref_clk), .arst_n(arst_n), .clkEn(clkEn),
    .progCounter(progCounter), .fetchWord(fetchWord));
  task tick;
    @(posedge ref_clk);
    #1;
  endtask
  task cmp(input string n, input logic [13:0] e, input logic [13:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task restart;
    arst_n = 1'b0;
    repeat (6) tick;
    arst_n = 1'b1;
  endtask
  task testSkip(input logic set, input logic [2:0] b);
    i_mem.mem[0] = {4'h7, b, 7'h05};
    i_mem.mem[1] = 14'h0111;
    i_mem.mem[2] = 14'h0222;
    regVal = set ? (8'h01 << b) : ~(8'h01 << b);
    restart;
    tick;
    cmp("faddr", 14'h0005, {7'h0, fileRdAddr});
    tick;
    cmp("skip", {13'h0, set}, {13'h0, skipTaken});
    tick;
    cmp("valid", {13'h0, !set}, {13'h0, execValid});
    cmp("word", set ? 14'h0000 : 14'h0111, execWord);
    tick;
    cmp("next", 14'h0222, execWord);
    $display("skip test set=%0d bit=%0d done", set, b);
  endtask
  task testCall(input logic [1:0] pg, input logic [10:0] k);
    i_mem.mem[0] = 14'h0111;
    i_mem.mem[1] = {3'h4, k};
    i_mem.mem[{pg, k}] = 14'h0333;
    latch = {3'h7, pg, 3'h7};
    restart;
    repeat (2) tick;
    cmp("plain", 14'h0111, execWord);
    tick;
    cmp("push", 14'h0001, {13'h0, stackPush});
    cmp("top", 14'h0002, {1'b0, stackTopEntry});
    cmp("pc", {1'b0, pg, k}, {1'b0, progCounter});
    tick;
    cmp("gap", 14'h0000, {13'h0, execValid});
    tick;
    cmp("target", 14'h0333, execWord);
    $display("call test page=%0d done", pg);
  endtask
  task testSkipCall;
    i_mem.mem[0] = {4'h7, 3'h2, 7'h05};
    i_mem.mem[1] = {3'h4, 11'h123};
    i_mem.mem[2] = 14'h0222;
    regVal = 8'h04;
    restart;
    repeat (2) tick;
    cmp("skipcall", 14'h0001, {13'h0, skipTaken});
    tick;
    cmp("nopush", 14'h0000, {13'h0, stackPush});
    cmp("nojump", 14'h0003, {1'b0, progCounter});
    cmp("keeptop", 14'h0000, {1'b0, stackTopEntry});
    cmp("nop", 14'h0000, execWord);
    tick;
    cmp("after", 14'h0222, execWord);
    $display("skip over call test done");
  endtask
  task testFreeze;
    i_mem.mem[0] = 14'h0111;
    i_mem.mem[1] = {3'h4, 11'h0AA};
    i_mem.mem[{2'h1, 11'h0AA}] = 14'h0333;
    latch = 8'h08;
    restart;
    repeat (2) tick;
    clkEn = 1'b0;
    repeat (3) tick;
    cmp("frzword", 14'h0111, execWord);
    cmp("frzpc", 14'h0002, {1'b0, progCounter});
    cmp("frzpush", 14'h0000, {13'h0, stackPush});
    clkEn = 1'b1;
    tick;
    cmp("frzcall", 14'h0001, {13'h0, stackPush});
    clkEn = 1'b0;
    repeat (2) tick;
    cmp("frzhold", 14'h0001, {13'h0, stackPush});
    cmp("frztop", 14'h0002, {1'b0, stackTopEntry});
    cmp("frzdest", 14'h08AA, {1'b0, progCounter});
    clkEn = 1'b1;
    tick;
    cmp("frzgap", 14'h0000, {13'h0, execValid});
    tick;
    cmp("frztarget", 14'h0333, execWord);
    $display("clock enable test done");
  endtask
  task conclude;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    for (int b = 0; b < 8; b++) begin
      testSkip(1'b1, b[2:0]);
      testSkip(1'b0, b[2:0]);
    end
    for (int j = 0; j < 4; j++) testCall(j[1:0], {j[1:0], 9'h155});
    testCall(2'h3, 11'h7FF);
    testSkipCall;
    testFreeze;
    conclude;
  end
endmodule
